//--- verilog/pcrs_top.sv
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "pcrs_params.svh"

// Notes on behaviour
// - The program counter is thirteen bits wide.
// - Its low eight bits form a byte register that software can read and write.
// - Bits twelve to eight cannot be read or written directly; a low byte write loads them from the latch.
// - Any reset clears the whole program counter.
// - A write to the low byte loads that byte and copies all five latch bits to the top.
// - A jump or call takes its two top bits from latch bits four and three.
// - A return stack holds eight saved counter values of thirteen bits each.
// - The stack and its pointer are outside every address space and invisible to software.
// - A call or an interrupt vector pushes the counter onto the stack.
// - A return pops the stack into the counter.
// - Pushes and pops never change the latch.
// - The stack is circular, so the ninth push overwrites the first.
// - Stack overflow and underflow raise no flag of any kind.
// - The stack moves only through calls, returns and vectoring, never by command.

module pcrs_top (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic INC_STB,
    input wire logic GOTO_STB,
    input wire logic CALL_STB,
    input wire logic RET_STB,
    input wire logic VEC_STB,
    input wire logic [`PCRS_LIT_W-1:0] LIT_ADDR,
    output logic [`PCRS_PC_W-1:0] PC_OUT
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [`PCRS_PC_W-1:0] pc_ff;
    logic [`PCRS_PC_W-1:0] nxt_pc;
    logic [`PCRS_LATCH_W-1:0] latch_ff;
    logic [`PCRS_LATCH_W-1:0] nxt_latch;
    pcrs_pkg::pcrs_op_t op;
    logic wr_low;
    logic wr_latch;
    logic push;
    logic pop;
    logic [`PCRS_PC_W-1:0] pop_data;
    logic [`PCRS_SP_W-1:0] sp;
    logic [`PCRS_PC_W-1:0] jump_target;

    // ----------------------------------------
    // Register bus
    // ----------------------------------------

    // Only the low byte and the latch are mapped; the stack pointer never is
    pcrs_bus_slave u_bus (
        .clk(CLK),
        .rst(SYS_RST),
        .address(AVS_ADDRESS),
        .read(AVS_READ),
        .write(AVS_WRITE),
        .writedata(AVS_WRITEDATA),
        .byteenable(AVS_BYTEENABLE),
        .low_val(pc_ff[`PCRS_LOW_W-1:0]),
        .latch_val(latch_ff),
        .readdata(AVS_READDATA),
        .waitrequest(AVS_WAITREQUEST),
        .wr_low(wr_low),
        .wr_latch(wr_latch)
    );

    // ----------------------------------------
    // Load source selection
    // ----------------------------------------

    // Vectoring beats every instruction; a bus write to the low byte loses to every
    // instruction but an increment in the same cycle, since the core owns the counter first
    always_comb begin
        op = pcrs_pkg::PCRS_OP_HOLD;
        if (VEC_STB) begin
            op = pcrs_pkg::PCRS_OP_VEC;
        end else if (CALL_STB) begin
            op = pcrs_pkg::PCRS_OP_CALL;
        end else if (GOTO_STB) begin
            op = pcrs_pkg::PCRS_OP_GOTO;
        end else if (RET_STB) begin
            op = pcrs_pkg::PCRS_OP_RET;
        end else if (wr_low) begin
            op = pcrs_pkg::PCRS_OP_WRLOW;
        end else if (INC_STB) begin
            op = pcrs_pkg::PCRS_OP_INC;
        end
    end

    // Long jumps only reach within the 2K page picked by the latch
    assign jump_target = {latch_ff[4:3], LIT_ADDR};

    // Stack moves only as a side effect of these three sources
    assign push = (op == pcrs_pkg::PCRS_OP_CALL) || (op == pcrs_pkg::PCRS_OP_VEC);
    assign pop = (op == pcrs_pkg::PCRS_OP_RET);

    // ----------------------------------------
    // Return stack
    // ----------------------------------------

    // No status leaves the stack: pointer wrap is silent by design
    pcrs_stack u_stack (
        .clk(CLK),
        .rst(SYS_RST),
        .push(push),
        .pop(pop),
        .push_data(pc_ff),
        .pop_data(pop_data),
        .sp(sp)
    );

    // ----------------------------------------
    // Program counter and latch
    // ----------------------------------------

    // Next counter value; the upper bits have no bus path of their own
    always_comb begin
        nxt_pc = pc_ff;
        case (op)
            pcrs_pkg::PCRS_OP_VEC: begin
                nxt_pc = `PCRS_VECTOR;
            end
            pcrs_pkg::PCRS_OP_CALL: begin
                nxt_pc = jump_target;
            end
            pcrs_pkg::PCRS_OP_GOTO: begin
                nxt_pc = jump_target;
            end
            pcrs_pkg::PCRS_OP_RET: begin
                nxt_pc = pop_data;
            end
            pcrs_pkg::PCRS_OP_WRLOW: begin
                // Table crossing a 256-byte block still uses the stale latch
                nxt_pc = {latch_ff, AVS_WRITEDATA[`PCRS_LOW_W-1:0]};
            end
            pcrs_pkg::PCRS_OP_INC: begin
                nxt_pc = pc_ff + `PCRS_PC_W'(1);
            end
            default: begin
                nxt_pc = pc_ff;
            end
        endcase
    end

    // Latch follows software only; stack traffic leaves it alone
    always_comb begin
        nxt_latch = latch_ff;
        if (wr_latch) begin
            nxt_latch = AVS_WRITEDATA[`PCRS_LATCH_W-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pc_ff <= `PCRS_PC_RST;
            latch_ff <= `PCRS_LATCH_RST;
        end else begin
            pc_ff <= nxt_pc;
            latch_ff <= nxt_latch;
        end
    end

    assign PC_OUT = pc_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------

    chk_reset_clears_pc: assert property (@(posedge CLK) SYS_RST |=> pc_ff == `PCRS_PC_RST)
        else $error("counter not cleared by reset");

    chk_goto_loads: assert property (@(posedge CLK) disable iff (SYS_RST)
        GOTO_STB && !CALL_STB && !VEC_STB
        |=> pc_ff == {$past(latch_ff[4:3]), $past(LIT_ADDR)})
        else $error("jump target not built from latch and literal");

    chk_call_loads_push: assert property (@(posedge CLK) disable iff (SYS_RST)
        CALL_STB && !VEC_STB
        |=> pc_ff[`PCRS_LIT_W-1:0] == $past(LIT_ADDR) && sp == $past(sp) + `PCRS_SP_W'(1))
        else $error("call did not load literal and push");

    chk_call_ret_pair: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CALL_STB && !VEC_STB) ##1 (RET_STB && !CALL_STB && !GOTO_STB && !VEC_STB)
        |=> pc_ff == $past(pc_ff, 2))
        else $error("return did not restore the caller address");

    chk_vector_loads: assert property (@(posedge CLK) disable iff (SYS_RST)
        VEC_STB |=> pc_ff == `PCRS_VECTOR && sp == $past(sp) + `PCRS_SP_W'(1))
        else $error("vectoring did not load vector and push");

    chk_low_write_load: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_low && !VEC_STB && !CALL_STB && !GOTO_STB && !RET_STB
        |=> pc_ff == {$past(latch_ff), $past(AVS_WRITEDATA[`PCRS_LOW_W-1:0])})
        else $error("low byte write did not copy latch into top bits");

    chk_latch_untouched: assert property (@(posedge CLK) disable iff (SYS_RST)
        (push || pop) && !wr_latch |=> $stable(latch_ff))
        else $error("latch changed by stack traffic");

    chk_hold_idle: assert property (@(posedge CLK) disable iff (SYS_RST)
        !VEC_STB && !CALL_STB && !GOTO_STB && !RET_STB && !wr_low && !INC_STB
        |=> $stable(pc_ff))
        else $error("counter moved with no cause");

    chk_increment_step: assert property (@(posedge CLK) disable iff (SYS_RST)
        INC_STB && !VEC_STB && !CALL_STB && !GOTO_STB && !RET_STB && !wr_low
        |=> pc_ff == $past(pc_ff) + `PCRS_PC_W'(1))
        else $error("increment did not step by one");

    chk_read_upper_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `PCRS_ADDR_LOW
        |-> AVS_READDATA == {24'h00_0000, $past(pc_ff[`PCRS_LOW_W-1:0])})
        else $error("low byte readback wrong or upper bits exposed");

    chk_answer_one_cycle: assert property (@(posedge CLK) disable iff (SYS_RST)
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus answer not given in one cycle");

    // ----------------------------------------
    // Stack traffic, latch and bus checks
    // ----------------------------------------

    // A plain jump must never disturb the hidden pointer
    chk_goto_no_push: assert property (@(posedge CLK) disable iff (SYS_RST)
        GOTO_STB && !CALL_STB && !VEC_STB |=> $stable(sp))
        else $error("jump moved the stack");

    chk_inc_no_push: assert property (@(posedge CLK) disable iff (SYS_RST)
        INC_STB && !VEC_STB && !CALL_STB && !GOTO_STB && !RET_STB |=> $stable(sp))
        else $error("increment moved the stack");

    // Bus writes reach the counter but never the stack
    chk_bus_no_push: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_low && !VEC_STB && !CALL_STB && !GOTO_STB && !RET_STB |=> $stable(sp))
        else $error("bus write moved the stack");

    chk_ret_ptr_back: assert property (@(posedge CLK) disable iff (SYS_RST)
        RET_STB && !VEC_STB && !CALL_STB && !GOTO_STB
        |=> sp == $past(sp) - `PCRS_SP_W'(1))
        else $error("return did not pop the stack");

    chk_ret_loads_top: assert property (@(posedge CLK) disable iff (SYS_RST)
        RET_STB && !VEC_STB && !CALL_STB && !GOTO_STB |=> pc_ff == $past(pop_data))
        else $error("return did not load the top entry");

    // A push saves the counter as it stood in the pushing cycle
    chk_push_saves_pc: assert property (@(posedge CLK) disable iff (SYS_RST)
        push ##1 (pop && !push) |-> pop_data == $past(pc_ff))
        else $error("pushed value is not the old counter");

    chk_jump_top_bits: assert property (@(posedge CLK) disable iff (SYS_RST)
        (GOTO_STB || CALL_STB) && !VEC_STB |=> pc_ff[12:11] == $past(latch_ff[4:3]))
        else $error("jump top bits not from latch");

    // The latch only ever changes through its own bus write
    chk_latch_write: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_latch |=> latch_ff == $past(AVS_WRITEDATA[`PCRS_LATCH_W-1:0]))
        else $error("latch write did not land");

    chk_latch_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
        !wr_latch |=> $stable(latch_ff))
        else $error("latch changed without a write");

    // Each answer lasts exactly one cycle, so no access is taken twice
    chk_answer_once: assert property (@(posedge CLK) disable iff (SYS_RST)
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("bus answer held for more than one cycle");

    chk_reset_bus_idle: assert property (@(posedge CLK)
        SYS_RST |=> AVS_WAITREQUEST && AVS_READDATA == `PCRS_RDATA_RST)
        else $error("bus not idle after reset");

endmodule

//--- inc/pcrs_params.svh
`ifndef PCRS_PARAMS_SVH
`define PCRS_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define PCRS_PC_W 13
`define PCRS_LOW_W 8
`define PCRS_LATCH_W 5
`define PCRS_LIT_W 11
`define PCRS_DEPTH 8
`define PCRS_SP_W 3

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PCRS_ADDR_LOW 4'h0
`define PCRS_ADDR_LATCH 4'h4

// ----------------------------------------
// Reset values and fixed addresses
// ----------------------------------------
`define PCRS_PC_RST 13'h0000
`define PCRS_LATCH_RST 5'h00
`define PCRS_SP_RST 3'h0
`define PCRS_VECTOR 13'h0004
`define PCRS_RDATA_RST 32'h0000_0000

`endif

//--- inc/pcrs_pkg.sv
package pcrs_pkg;

    // ----------------------------------------
    // Bus handshake states
    // ----------------------------------------
    typedef enum logic [0:0] {
        PCRS_BUS_IDLE,
        PCRS_BUS_ACK
    } pcrs_bus_state_t;

    // ----------------------------------------
    // Counter load source; the top sets the priority, not this order
    // ----------------------------------------
    typedef enum logic [2:0] {
        PCRS_OP_HOLD,
        PCRS_OP_INC,
        PCRS_OP_WRLOW,
        PCRS_OP_GOTO,
        PCRS_OP_CALL,
        PCRS_OP_RET,
        PCRS_OP_VEC
    } pcrs_op_t;

endpackage

//--- verilog/pcrs_stack.sv
`timescale 1ns/1ps
`include "pcrs_params.svh"

module pcrs_stack (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic pop,
    input wire logic [`PCRS_PC_W-1:0] push_data,
    output logic [`PCRS_PC_W-1:0] pop_data,
    output logic [`PCRS_SP_W-1:0] sp
);

    logic [`PCRS_PC_W-1:0] mem_ff [`PCRS_DEPTH];
    logic [`PCRS_SP_W-1:0] sp_ff;
    logic [`PCRS_SP_W-1:0] nxt_sp;

    // Pointer wraps freely: no overflow or underflow is ever flagged
    always_comb begin
        nxt_sp = sp_ff;
        if (push) begin
            nxt_sp = sp_ff + `PCRS_SP_W'(1);
        end else if (pop) begin
            nxt_sp = sp_ff - `PCRS_SP_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sp_ff <= `PCRS_SP_RST;
        end else begin
            sp_ff <= nxt_sp;
        end
    end

    // One entry per slot; a push overwrites whatever the slot held
    genvar gi;
    generate
        for (gi = 0; gi < `PCRS_DEPTH; gi = gi + 1) begin : g_entry
            logic [`PCRS_PC_W-1:0] nxt_entry;
            always_comb begin
                nxt_entry = mem_ff[gi];
                if (push && sp_ff == `PCRS_SP_W'(gi)) begin
                    nxt_entry = push_data;
                end
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem_ff[gi] <= `PCRS_PC_RST;
                end else begin
                    mem_ff[gi] <= nxt_entry;
                end
            end
        end
    endgenerate

    // Top of stack is the slot below the pointer, wrapping on an empty stack
    assign pop_data = mem_ff[sp_ff - `PCRS_SP_W'(1)];
    assign sp = sp_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_push_ptr_step: assert property (push |=> sp_ff == $past(sp_ff) + `PCRS_SP_W'(1))
        else $error("stack pointer did not advance on push");
    chk_pop_ptr_step: assert property (pop && !push |=> sp_ff == $past(sp_ff) - `PCRS_SP_W'(1))
        else $error("stack pointer did not step back on pop");
    chk_push_then_pop: assert property (push ##1 (pop && !push) |-> pop_data == $past(push_data))
        else $error("pop did not return the value just pushed");

endmodule

//--- verilog/pcrs_bus_slave.sv
`timescale 1ns/1ps
`include "pcrs_params.svh"

module pcrs_bus_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [`PCRS_LOW_W-1:0] low_val,
    input wire logic [`PCRS_LATCH_W-1:0] latch_val,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic wr_low,
    output logic wr_latch
);

    pcrs_pkg::pcrs_bus_state_t state_ff;
    pcrs_pkg::pcrs_bus_state_t nxt_state;
    logic wait_ff;
    logic nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // Every access answers one cycle after it appears; read data is captured then
    always_comb begin
        nxt_state = state_ff;
        nxt_wait = 1'b1;
        nxt_rdata = rdata_ff;
        case (state_ff)
            pcrs_pkg::PCRS_BUS_IDLE: begin
                if (read || write) begin
                    nxt_state = pcrs_pkg::PCRS_BUS_ACK;
                    nxt_wait = 1'b0;
                    nxt_rdata = `PCRS_RDATA_RST; // Unmapped and upper bits read zero
                    if (read && address == `PCRS_ADDR_LOW) begin
                        nxt_rdata[`PCRS_LOW_W-1:0] = low_val;
                    end else if (read && address == `PCRS_ADDR_LATCH) begin
                        nxt_rdata[`PCRS_LATCH_W-1:0] = latch_val;
                    end
                end
            end
            pcrs_pkg::PCRS_BUS_ACK: begin
                nxt_state = pcrs_pkg::PCRS_BUS_IDLE;
            end
            default: begin
                nxt_state = pcrs_pkg::PCRS_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= pcrs_pkg::PCRS_BUS_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= `PCRS_RDATA_RST;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // Writes land at the edge where the master sees waitrequest low
    assign wr_low = write && !wait_ff && byteenable[0] && address == `PCRS_ADDR_LOW;
    assign wr_latch = write && !wait_ff && byteenable[0] && address == `PCRS_ADDR_LATCH;
    assign readdata = rdata_ff;
    assign waitrequest = wait_ff;

endmodule

//--- tb/pcrs_core_model.sv
`timescale 1ns/1ps
`include "pcrs_params.svh"

// ----------------------------------------
// Decoder and interrupt side of the core
// ----------------------------------------
module pcrs_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire pcrs_pkg::pcrs_op_t op,
    input wire logic [`PCRS_LIT_W-1:0] lit,
    output logic inc_stb,
    output logic goto_stb,
    output logic call_stb,
    output logic ret_stb,
    output logic vec_stb,
    output logic [`PCRS_LIT_W-1:0] lit_addr
);
    logic [`PCRS_LIT_W-1:0] last_lit_ff;
    logic [`PCRS_LIT_W-1:0] nxt_last_lit;
    logic jump;

    // One strobe per executed instruction; stack moves only as a side effect
    always_comb begin
        inc_stb = (op == pcrs_pkg::PCRS_OP_INC);
        goto_stb = (op == pcrs_pkg::PCRS_OP_GOTO);
        call_stb = (op == pcrs_pkg::PCRS_OP_CALL);
        ret_stb = (op == pcrs_pkg::PCRS_OP_RET);
        vec_stb = (op == pcrs_pkg::PCRS_OP_VEC);
        jump = goto_stb | call_stb;
        nxt_last_lit = jump ? lit : last_lit_ff;
        // Literal is only valid with a jump, so a stale value must not look valid
        lit_addr = jump ? lit : ~last_lit_ff;
    end

    // Remember the last literal so idle cycles show its inverse
    always_ff @(posedge clk) begin
        last_lit_ff <= rst ? 11'h000 : nxt_last_lit;
    end
endmodule

//--- tb/tb_program_counter_return_stack.sv
`timescale 1ns/1ps
`include "pcrs_params.svh"

module tb_program_counter_return_stack;
    typedef struct packed {
        pcrs_pkg::pcrs_op_t op;
        logic [10:0] lit;
        logic [12:0] pc;
    } pcrs_row_t;

    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic [3:0] AVS_BYTEENABLE = 4'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic INC_STB, GOTO_STB, CALL_STB, RET_STB, VEC_STB;
    logic [10:0] LIT_ADDR;
    logic [12:0] PC_OUT;
    pcrs_pkg::pcrs_op_t op = pcrs_pkg::PCRS_OP_HOLD;
    logic [10:0] lit = 11'h000;
    logic [31:0] rd;
    pcrs_row_t rows [7];
    int n_errors = 0;
    int checks = 0;

    // ----------------------------------------
    // Clock, design and core model
    // ----------------------------------------
    initial begin
        forever #10 CLK = ~CLK;
    end

    pcrs_top u_pcrs_top (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .INC_STB(INC_STB), .GOTO_STB(GOTO_STB),
        .CALL_STB(CALL_STB), .RET_STB(RET_STB), .VEC_STB(VEC_STB),
        .LIT_ADDR(LIT_ADDR), .PC_OUT(PC_OUT));

    pcrs_core_model u_pcrs_core_model (.clk(CLK), .rst(SYS_RST), .op(op), .lit(lit),
        .inc_stb(INC_STB), .goto_stb(GOTO_STB), .call_stb(CALL_STB), .ret_stb(RET_STB),
        .vec_stb(VEC_STB), .lit_addr(LIT_ADDR));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Avalon access: hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int k;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (AVS_WAITREQUEST !== 1'b0 && k < 20);
        if (k >= 20) begin
            n_errors++;
            $display("unexpected at %0t: bus hang", $time);
            tally_and_finish();
        end
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        #1;
    endtask

    // One instruction for one cycle; counter is settled just after the next edge
    task automatic core(input pcrs_pkg::pcrs_op_t o, input logic [10:0] l);
        @(posedge CLK);
        op <= o;
        lit <= l;
        @(posedge CLK);
        op <= pcrs_pkg::PCRS_OP_HOLD;
        #1;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        // Interrupt inside a call, latch holding all ones
        rows[0] = '{pcrs_pkg::PCRS_OP_GOTO, 11'h123, 13'h1923};
        rows[1] = '{pcrs_pkg::PCRS_OP_INC, 11'h000, 13'h1924};
        rows[2] = '{pcrs_pkg::PCRS_OP_CALL, 11'h055, 13'h1855};
        rows[3] = '{pcrs_pkg::PCRS_OP_VEC, 11'h000, 13'h0004};
        rows[4] = '{pcrs_pkg::PCRS_OP_RET, 11'h000, 13'h1855};
        rows[5] = '{pcrs_pkg::PCRS_OP_RET, 11'h000, 13'h1924};
        rows[6] = '{pcrs_pkg::PCRS_OP_INC, 11'h000, 13'h1925};
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'b0;
        #1;
        chk({19'h0_0000, PC_OUT}, 32'h0000_0000);
        chk({31'h0000_0000, AVS_WAITREQUEST}, 32'h0000_0001);
        chk(AVS_READDATA, 32'h0000_0000);
        bus(1'b1, 4'h4, 32'h0000_001F, 4'h1);
        foreach (rows[i]) begin
            core(rows[i].op, rows[i].lit);
            chk({19'h0_0000, PC_OUT}, {19'h0_0000, rows[i].pc});
        end
        // Latch survives pushes and pops
        bus(1'b0, 4'h4, 32'h0000_0000, 4'h1);
        chk(rd, 32'h0000_001F);
        // Low byte write pulls all five latch bits into the top
        bus(1'b1, 4'h0, 32'h0000_00A5, 4'h1);
        chk({19'h0_0000, PC_OUT}, 32'h0000_1FA5);
        bus(1'b0, 4'h0, 32'h0000_0000, 4'h1);
        chk(rd, 32'h0000_00A5);
        // Disabled byte lane must leave the counter alone
        bus(1'b1, 4'h0, 32'h0000_0033, 4'h0);
        chk({19'h0_0000, PC_OUT}, 32'h0000_1FA5);
        // Nothing else of the counter or stack shows on the bus
        bus(1'b0, 4'h8, 32'h0000_0000, 4'h1);
        chk(rd, 32'h0000_0000);
        // Jump takes only latch bits 4:3; low write takes all five
        bus(1'b1, 4'h4, 32'h0000_0007, 4'h1);
        core(pcrs_pkg::PCRS_OP_GOTO, 11'h7FF);
        chk({19'h0_0000, PC_OUT}, 32'h0000_07FF);
        bus(1'b1, 4'h0, 32'h0000_0010, 4'h1);
        chk({19'h0_0000, PC_OUT}, 32'h0000_0710);
        // Increment wraps at thirteen bits
        bus(1'b1, 4'h4, 32'h0000_001F, 4'h1);
        bus(1'b1, 4'h0, 32'h0000_00FF, 4'h1);
        core(pcrs_pkg::PCRS_OP_INC, 11'h000);
        chk({19'h0_0000, PC_OUT}, 32'h0000_0000);
        // Ten calls overflow eight slots silently; the two oldest are lost
        for (int i = 0; i < 10; i++) begin
            core(pcrs_pkg::PCRS_OP_CALL, 11'(i));
        end
        for (int k = 0; k < 8; k++) begin
            core(pcrs_pkg::PCRS_OP_RET, 11'h000);
            chk({19'h0_0000, PC_OUT}, 32'h0000_1808 - 32'(k));
        end
        // Ninth pop wraps round to the newest slot
        core(pcrs_pkg::PCRS_OP_RET, 11'h000);
        chk({19'h0_0000, PC_OUT}, 32'h0000_1808);
        // Call followed at once by a return lands back on the caller
        @(posedge CLK);
        op <= pcrs_pkg::PCRS_OP_CALL;
        lit <= 11'h2AA;
        @(posedge CLK);
        op <= pcrs_pkg::PCRS_OP_RET;
        @(posedge CLK);
        op <= pcrs_pkg::PCRS_OP_HOLD;
        #1;
        chk({19'h0_0000, PC_OUT}, 32'h0000_1808);
        // Reset in mid-run clears the counter again
        @(posedge CLK);
        SYS_RST <= 1'b1;
        @(posedge CLK);
        SYS_RST <= 1'b0;
        #1;
        chk({19'h0_0000, PC_OUT}, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
